// [src/boot_usb_descriptor_rom.sv]
// Default boot descriptor table served byte by byte to control endpoint zero
`timescale 1ns/1ps
`include "budr_consts.svh"

// How it works
// - Interface descriptor, nine bytes, type four.
// - Interface number and alternate setting both zero.
// - Interface declares one endpoint besides zero.
// - Vendor class FF, subclass, protocol, string zero.
// - Endpoint descriptor, seven bytes, type five.
// - Endpoint address 01: number one, OUT.
// - Endpoint attributes 2 select bulk transfers.
// - Bulk OUT endpoint maximum packet 64 bytes.
// - Endpoint polling interval is zero.
// - String zero: four bytes, language 0409.
// - Strings use type 03, two-byte characters.
// - Each character: code byte, then 00.
// - Indices one, two, three: maker, product, serial.
// - Manufacturer string total length 36.
// - Product string total length 42.
// - Serial string total length 34.
// - Sixteen hex digits from eight serial bytes.
// - Configuration total length 25 bytes.
// - Device descriptor points to strings one-three.
module boot_usb_descriptor_rom #(
  // Identity codes below are arbitrary neutral values
  parameter logic [15:0]   VENDOR_CODE  = 16'hA5A5,
  parameter logic [15:0]   PRODUCT_CODE = 16'h5A5A,
  // Text is stored first character in the top byte
  parameter logic [135:0]  MFG_TEXT     = "Vendor Boot Maker",
  parameter logic [159:0]  PRODUCT_TEXT = "Generic boot devices"
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         setupValid,
  input  wire logic [7:0]   setupRequestType,
  input  wire logic [7:0]   setupRequest,
  input  wire logic [15:0]  setupValue,
  input  wire logic [15:0]  setupLength,
  input  wire logic [63:0]  serialNumberBytes,
  input  wire logic         dataReady,
  output logic              dataValid,
  output logic [7:0]        dataByte,
  output logic              dataLast,
  output logic              reqDone,
  output logic              reqStall
);
  import budr_pkg::*;

  // ========================================================================
  // Table lookups

  function automatic logic [7:0] devByte(input logic [7:0] off);
    logic [7:0] b;
    b = `BUDR_ZERO;
    unique case (off)
      8'h00: b = `BUDR_LEN_DEVICE;
      8'h01: b = `BUDR_TYPE_DEVICE;
      8'h02: b = 8'(`BUDR_BCD_USB);
      8'h03: b = 8'(`BUDR_BCD_USB >> 8);
      8'h04: b = `BUDR_CLASS_VENDOR;
      8'h05: b = `BUDR_ZERO;
      8'h06: b = `BUDR_ZERO;
      8'h07: b = `BUDR_EP0_MAX_PACKET;
      8'h08: b = VENDOR_CODE[7:0];
      8'h09: b = VENDOR_CODE[15:8];
      8'h0A: b = PRODUCT_CODE[7:0];
      8'h0B: b = PRODUCT_CODE[15:8];
      8'h0C: b = 8'(`BUDR_BCD_DEVICE);
      8'h0D: b = 8'(`BUDR_BCD_DEVICE >> 8);
      8'h0E: b = `BUDR_STR_MFG;
      8'h0F: b = `BUDR_STR_PRODUCT;
      8'h10: b = `BUDR_STR_SERIAL;
      8'h11: b = `BUDR_ONE;
      default: b = `BUDR_ZERO;
    endcase
    return b;
  endfunction : devByte

  // Configuration, interface and endpoint descriptors as one bundle
  function automatic logic [7:0] cfgByte(input logic [7:0] off);
    logic [7:0] b;
    b = `BUDR_ZERO;
    unique case (off)
      8'h00: b = `BUDR_LEN_CONFIG;
      8'h01: b = `BUDR_TYPE_CONFIG;
      8'h02: b = `BUDR_LEN_CFG_TOTAL;
      8'h03: b = `BUDR_ZERO;
      8'h04: b = `BUDR_ONE;
      8'h05: b = `BUDR_ONE;
      8'h06: b = `BUDR_ZERO;
      8'h07: b = `BUDR_CFG_ATTRIBUTES;
      8'h08: b = `BUDR_CFG_MAX_POWER;
      8'h09: b = `BUDR_LEN_INTERFACE;
      8'h0A: b = `BUDR_TYPE_INTERFACE;
      8'h0B: b = `BUDR_ZERO;
      8'h0C: b = `BUDR_ZERO;
      8'h0D: b = `BUDR_ONE;
      8'h0E: b = `BUDR_CLASS_VENDOR;
      8'h0F: b = `BUDR_ZERO;
      8'h10: b = `BUDR_ZERO;
      8'h11: b = `BUDR_ZERO;
      8'h12: b = `BUDR_LEN_ENDPOINT;
      8'h13: b = `BUDR_TYPE_ENDPOINT;
      8'h14: b = `BUDR_EP_ADDRESS;
      8'h15: b = `BUDR_EP_ATTR_BULK;
      8'h16: b = 8'(`BUDR_EP_MAX_PACKET);
      8'h17: b = 8'(`BUDR_EP_MAX_PACKET >> 8);
      8'h18: b = `BUDR_ZERO;
      default: b = `BUDR_ZERO;
    endcase
    return b;
  endfunction : cfgByte

  function automatic logic [7:0] hexDigit(input logic [3:0] nib);
    logic [7:0] b;
    b = `BUDR_ZERO;
    if (nib < 4'hA) begin
      b = `BUDR_ASCII_ZERO + {4'h0, nib};
    end else begin
      b = `BUDR_ASCII_A_MINUS_10 + {4'h0, nib};
    end
    return b;
  endfunction : hexDigit

  // Character number chr of string sel, as a code byte
  function automatic logic [7:0] strChar(input budr_sel_t  sel,
                                         input logic [7:0] chr,
                                         input logic [63:0] serial);
    logic [7:0] b;
    logic [7:0] sByte;
    b = `BUDR_ZERO;
    sByte = `BUDR_ZERO;
    unique case (sel)
      BUDR_SEL_STR1: begin
        if (chr < 8'd17) begin
          b = MFG_TEXT[(8'd16 - chr) * 8 +: 8];
        end
      end
      BUDR_SEL_STR2: begin
        if (chr < 8'd20) begin
          b = PRODUCT_TEXT[(8'd19 - chr) * 8 +: 8];
        end
      end
      BUDR_SEL_STR3: begin
        // First register first, high nibble before low nibble
        if (chr < 8'd16) begin
          sByte = serial[chr[3:1] * 8 +: 8];
          b = chr[0] ? hexDigit(sByte[3:0]) : hexDigit(sByte[7:4]);
        end
      end
      default: b = `BUDR_ZERO;
    endcase
    return b;
  endfunction : strChar

  function automatic logic [7:0] strLen(input budr_sel_t sel);
    logic [7:0] b;
    b = `BUDR_ZERO;
    unique case (sel)
      BUDR_SEL_STR0: b = `BUDR_LEN_STR0;
      BUDR_SEL_STR1: b = `BUDR_LEN_STR1;
      BUDR_SEL_STR2: b = `BUDR_LEN_STR2;
      BUDR_SEL_STR3: b = `BUDR_LEN_STR3;
      default: b = `BUDR_ZERO;
    endcase
    return b;
  endfunction : strLen

  function automatic logic [7:0] strByte(input budr_sel_t   sel,
                                         input logic [7:0]  off,
                                         input logic [63:0] serial);
    logic [7:0] b;
    logic [7:0] chr;
    b = `BUDR_ZERO;
    chr = (off - 8'd2) >> 1;
    if (off == 8'h00) begin
      b = strLen(sel);
    end else if (off == 8'h01) begin
      b = `BUDR_TYPE_STRING;
    end else if (sel == BUDR_SEL_STR0) begin
      b = (off == 8'h02) ? 8'(`BUDR_LANGID) : 8'(`BUDR_LANGID >> 8);
    end else if (off[0]) begin
      b = `BUDR_ZERO;
    end else begin
      b = strChar(sel, chr, serial);
    end
    return b;
  endfunction : strByte

  function automatic logic [7:0] tableByte(input budr_sel_t   sel,
                                           input logic [7:0]  off,
                                           input logic [63:0] serial);
    logic [7:0] b;
    b = `BUDR_ZERO;
    unique case (sel)
      BUDR_SEL_DEV: b = devByte(off);
      BUDR_SEL_CFG: b = cfgByte(off);
      default:      b = strByte(sel, off, serial);
    endcase
    return b;
  endfunction : tableByte

  // ========================================================================
  // Request decode

  logic        isGetDesc;
  logic        descKnown;
  budr_sel_t   reqSel;
  logic [7:0]  reqBase;
  logic [7:0]  reqDescLen;
  logic [15:0] reqSendLen;
  logic [7:0]  reqLastOff;

  assign isGetDesc = (setupRequestType == `BUDR_REQTYPE_GET_DESC) &&
                     (setupRequest == `BUDR_REQ_GET_DESC);

  always_comb begin
    descKnown  = 1'b1;
    reqSel     = BUDR_SEL_DEV;
    reqBase    = `BUDR_ZERO;
    reqDescLen = `BUDR_LEN_DEVICE;
    unique case (setupValue[15:8])
      `BUDR_TYPE_DEVICE: begin
        descKnown = (setupValue[7:0] == `BUDR_ZERO);
      end
      `BUDR_TYPE_CONFIG: begin
        reqSel     = BUDR_SEL_CFG;
        reqDescLen = `BUDR_LEN_CFG_TOTAL;
        descKnown  = (setupValue[7:0] == `BUDR_ZERO);
      end
      `BUDR_TYPE_INTERFACE: begin
        reqSel     = BUDR_SEL_CFG;
        reqBase    = `BUDR_OFF_INTERFACE;
        reqDescLen = `BUDR_LEN_INTERFACE;
        descKnown  = (setupValue[7:0] == `BUDR_ZERO);
      end
      `BUDR_TYPE_ENDPOINT: begin
        reqSel     = BUDR_SEL_CFG;
        reqBase    = `BUDR_OFF_ENDPOINT;
        reqDescLen = `BUDR_LEN_ENDPOINT;
        descKnown  = (setupValue[7:0] == `BUDR_ZERO);
      end
      `BUDR_TYPE_STRING: begin
        descKnown = (setupValue[7:0] <= `BUDR_STR_SERIAL);
        reqSel    = budr_sel_t'(setupValue[2:0] + 3'h2);
        reqDescLen = strLen(budr_sel_t'(setupValue[2:0] + 3'h2));
      end
      default: begin
        descKnown = 1'b0;
      end
    endcase
  end

  // Clip to what the host asked for
  assign reqSendLen = (setupLength < {8'h00, reqDescLen}) ? setupLength
                                                          : {8'h00, reqDescLen};
  assign reqLastOff = reqBase + reqSendLen[7:0] - 8'd1;

  // ========================================================================
  // Byte sequencer

  budr_state_t state_r;
  budr_sel_t   sel_r;
  logic [7:0]  off_r;
  logic [7:0]  lastOff_r;
  logic [63:0] serial_r;
  logic        accept;
  logic        advance;
  logic        fetchNew;

  // Requests arriving mid-transfer are ignored
  assign accept   = setupValid && (state_r == BUDR_IDLE);
  assign fetchNew = accept && isGetDesc && descKnown && (reqSendLen != 16'h0000);
  assign advance  = (state_r == BUDR_SEND) && dataReady && !dataLast;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= BUDR_IDLE;
    end else begin
      unique case (state_r)
        BUDR_IDLE: begin
          if (fetchNew) begin
            state_r <= BUDR_SEND;
          end
        end
        BUDR_SEND: begin
          if (dataReady && dataLast) begin
            state_r <= BUDR_IDLE;
          end
        end
      endcase
    end
  end

  // Serial bytes are frozen per request so a string never mixes two values
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_r     <= BUDR_SEL_DEV;
      off_r     <= `BUDR_ZERO;
      lastOff_r <= `BUDR_ZERO;
      serial_r  <= 64'h0000000000000000;
    end else if (fetchNew) begin
      sel_r     <= reqSel;
      off_r     <= reqBase;
      lastOff_r <= reqLastOff;
      serial_r  <= serialNumberBytes;
    end else if (advance) begin
      off_r <= off_r + 8'd1;
    end
  end

  // ========================================================================
  // Output stream

  always_ff @(posedge clk) begin
    if (reset) begin
      dataValid <= 1'b0;
      dataByte  <= `BUDR_ZERO;
      dataLast  <= 1'b0;
    end else if (fetchNew) begin
      dataValid <= 1'b1;
      dataByte  <= tableByte(reqSel, reqBase, serialNumberBytes);
      dataLast  <= (reqBase == reqLastOff);
    end else if (advance) begin
      dataByte <= tableByte(sel_r, off_r + 8'd1, serial_r);
      dataLast <= ((off_r + 8'd1) == lastOff_r);
    end else if (dataValid && dataReady) begin
      dataValid <= 1'b0;
      dataLast  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reqDone  <= 1'b0;
      reqStall <= 1'b0;
    end else begin
      reqDone  <= (accept && isGetDesc && descKnown && (reqSendLen == 16'h0000)) ||
                  ((state_r == BUDR_SEND) && dataReady && dataLast);
      reqStall <= accept && !(isGetDesc && descKnown);
    end
  end

endmodule : boot_usb_descriptor_rom

// [include/budr_consts.svh]
// Constant values of the boot descriptor table: request codes, descriptor fields and lengths
`ifndef BUDR_CONSTS_SVH
`define BUDR_CONSTS_SVH

// ==========================================================================
// Standard request decode
`define BUDR_REQTYPE_GET_DESC  8'h80
`define BUDR_REQ_GET_DESC      8'h06

// ==========================================================================
// Descriptor type codes
`define BUDR_TYPE_DEVICE       8'h01
`define BUDR_TYPE_CONFIG       8'h02
`define BUDR_TYPE_STRING       8'h03
`define BUDR_TYPE_INTERFACE    8'h04
`define BUDR_TYPE_ENDPOINT     8'h05

// ==========================================================================
// Descriptor lengths and offsets inside the configuration bundle
`define BUDR_LEN_DEVICE        8'h12
`define BUDR_LEN_CONFIG        8'h09
`define BUDR_LEN_INTERFACE     8'h09
`define BUDR_LEN_ENDPOINT      8'h07
`define BUDR_LEN_CFG_TOTAL     8'h19
`define BUDR_OFF_INTERFACE     8'h09
`define BUDR_OFF_ENDPOINT      8'h12
`define BUDR_LEN_STR0          8'h04
`define BUDR_LEN_STR1          8'h24
`define BUDR_LEN_STR2          8'h2A
`define BUDR_LEN_STR3          8'h22

// ==========================================================================
// Field values
`define BUDR_ZERO              8'h00
`define BUDR_ONE               8'h01
`define BUDR_BCD_USB           16'h0110
`define BUDR_BCD_DEVICE        16'h0100
`define BUDR_CLASS_VENDOR      8'hFF
`define BUDR_EP0_MAX_PACKET    8'h08
`define BUDR_CFG_ATTRIBUTES    8'h80
`define BUDR_CFG_MAX_POWER     8'h32
`define BUDR_EP_ADDRESS        8'h01
`define BUDR_EP_ATTR_BULK      8'h02
`define BUDR_EP_MAX_PACKET     16'h0040
`define BUDR_LANGID            16'h0409
`define BUDR_STR_MFG           8'h01
`define BUDR_STR_PRODUCT       8'h02
`define BUDR_STR_SERIAL        8'h03
`define BUDR_ASCII_ZERO        8'h30
`define BUDR_ASCII_A_MINUS_10  8'h37

`endif

// [include/budr_pkg.sv]
// Types shared by the boot descriptor table
package budr_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    BUDR_IDLE = 2'b01,
    BUDR_SEND = 2'b10
  } budr_state_t;

  // ========================================================================
  // Which table a transfer reads from
  typedef enum logic [2:0] {
    BUDR_SEL_DEV  = 3'h0,
    BUDR_SEL_CFG  = 3'h1,
    BUDR_SEL_STR0 = 3'h2,
    BUDR_SEL_STR1 = 3'h3,
    BUDR_SEL_STR2 = 3'h4,
    BUDR_SEL_STR3 = 3'h5
  } budr_sel_t;

endpackage : budr_pkg

// [bench/budr_props.sv]
// Port-level checker for the boot descriptor table
`timescale 1ns/1ps
`include "budr_consts.svh"
module budr_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        setupValid,
  input wire logic [7:0]  setupRequestType,
  input wire logic [7:0]  setupRequest,
  input wire logic [15:0] setupValue,
  input wire logic [15:0] setupLength,
  input wire logic [63:0] serialNumberBytes,
  input wire logic        dataReady,
  input wire logic        dataValid,
  input wire logic [7:0]  dataByte,
  input wire logic        dataLast,
  input wire logic        reqDone,
  input wire logic        reqStall
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  logic getDesc;
  assign take = setupValid && !dataValid;
  assign getDesc = take && setupRequestType == `BUDR_REQTYPE_GET_DESC
                   && setupRequest == `BUDR_REQ_GET_DESC;

  // ========================================================================
  // Handshake
  chk_answer_once: assert property (take |=> $onehot({dataValid, reqDone, reqStall}))
    else $error("setup not answered by exactly one response");
  chk_byte_holds: assert property (dataValid && !dataReady |=>
    dataValid && $stable(dataByte) && $stable(dataLast)) else $error("offered byte moved");
  chk_done_follows: assert property (dataValid && dataLast && dataReady |=>
    !dataValid && reqDone) else $error("no done after last byte");
  chk_pulse_short: assert property (reqDone || reqStall |=> !reqDone && !reqStall)
    else $error("done or stall longer than one cycle");
  chk_bad_request: assert property (take && setupRequest != `BUDR_REQ_GET_DESC |=> reqStall)
    else $error("unsupported request not stalled");
  chk_zero_length: assert property (getDesc && setupValue == 16'h0100 && setupLength == 16'h0000
    |=> reqDone && !dataValid) else $error("zero length request sent data");
  chk_reset_quiet: assert property ($fell(reset) |-> !dataValid && !reqDone && !reqStall)
    else $error("outputs active after reset");

  // ========================================================================
  // Descriptor lengths
  chk_intf_length: assert property (getDesc && setupValue == 16'h0400 && setupLength != 16'h0000
    |=> dataValid && dataByte == `BUDR_LEN_INTERFACE) else $error("interface length wrong");
  chk_ep_length: assert property (getDesc && setupValue == 16'h0500 && setupLength != 16'h0000
    |=> dataValid && dataByte == `BUDR_LEN_ENDPOINT) else $error("endpoint length wrong");
  chk_serial_length: assert property (getDesc && setupValue == 16'h0303 && setupLength != 16'h0000
    |=> dataValid && dataByte == `BUDR_LEN_STR3) else $error("serial length wrong");

  cov_stall: cover property (reqStall);
  cov_last: cover property (dataValid && dataLast && dataReady);
  cov_wait: cover property (dataValid && !dataReady);
endmodule : budr_props

bind boot_usb_descriptor_rom budr_props i_props (
  .clk(clk), .reset(reset), .setupValid(setupValid), .setupRequestType(setupRequestType),
  .setupRequest(setupRequest), .setupValue(setupValue), .setupLength(setupLength),
  .serialNumberBytes(serialNumberBytes), .dataReady(dataReady), .dataValid(dataValid),
  .dataByte(dataByte), .dataLast(dataLast), .reqDone(reqDone), .reqStall(reqStall));

// [bench/budr_host_model.sv]
// Host side model: paces dataReady and collects descriptor bytes
`timescale 1ns/1ps
module budr_host_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slowMode,
  input  wire logic        setupValid,
  input  wire logic [15:0] setupLength,
  input  wire logic        dataValid,
  input  wire logic [7:0]  dataByte,
  input  wire logic        dataLast,
  output logic             dataReady,
  output logic             overRun
);
  logic [7:0]  rxBytes [0:63];
  int          rxCount;
  logic [15:0] wantLen_r;
  int          lastIdx;
  // A slow host takes a byte only every other cycle, so held bytes get seen
  always_ff @(posedge clk) begin
    if (reset) dataReady <= 1'b0;
    else dataReady <= slowMode ? ~dataReady : 1'b1;
  end
  always_ff @(posedge clk) begin
    if (reset || setupValid) begin
      rxCount <= 0;
      wantLen_r <= setupLength;
      overRun <= 1'b0;
      lastIdx <= -1;
    end else if (dataValid && dataReady) begin
      rxBytes[rxCount[5:0]] <= dataByte;
      rxCount <= rxCount + 1;
      if (dataLast) lastIdx <= rxCount;
      overRun <= overRun || (rxCount >= int'(wantLen_r));
    end
  end
endmodule : budr_host_model

// [bench/boot_usb_descriptor_rom_tb.sv]
// Self-checking bench for the boot descriptor table
`timescale 1ns/1ps
`include "budr_consts.svh"
module boot_usb_descriptor_rom_tb;
  typedef struct {logic [15:0] val; logic [15:0] len; int n; logic [199:0] exp;} budr_row_t;
  localparam logic [135:0] MFG = "Vendor Boot Maker";
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        slowMode = 1'b0;
  logic        setupValid = 1'b0;
  logic [7:0]  setupRequestType = 8'h00;
  logic [7:0]  setupRequest = 8'h00;
  logic [15:0] setupValue = 16'h0000;
  logic [15:0] setupLength = 16'h0000;
  logic [63:0] serialNumberBytes = 64'h0;
  logic        dataReady, dataValid, dataLast, reqDone, reqStall, overRun;
  logic [7:0]  dataByte;
  logic        sawStall;
  int          fails = 0;
  int          checked = 0;
  budr_row_t   rows [0:7] = '{
    '{16'h0400, 16'hFFFF, 9, 72'h0904000001FF000000},
    '{16'h0500, 16'hFFFF, 7, 56'h07050102400000},
    '{16'h0300, 16'hFFFF, 4, 32'h04030904},
    '{16'h0200, 16'hFFFF, 25,
      200'h0902190001010080320904000001FF00000007050102400000},
    '{16'h0100, 16'hFFFF, 18, 144'h12011001FF000008A5A55A5A000101020301},
    '{16'h0200, 16'h0004, 4, 32'h09021900},
    '{16'h0301, 16'h0002, 2, 16'h2403},
    '{16'h0302, 16'h0003, 3, 24'h2A0347}};

  always #2.5 clk = ~clk;

  boot_usb_descriptor_rom #(.MFG_TEXT(MFG)) i_dut (
    .clk(clk), .reset(reset), .setupValid(setupValid), .setupRequestType(setupRequestType),
    .setupRequest(setupRequest), .setupValue(setupValue), .setupLength(setupLength),
    .serialNumberBytes(serialNumberBytes), .dataReady(dataReady), .dataValid(dataValid),
    .dataByte(dataByte), .dataLast(dataLast), .reqDone(reqDone), .reqStall(reqStall));
  budr_host_model i_host (
    .clk(clk), .reset(reset), .slowMode(slowMode), .setupValid(setupValid),
    .setupLength(setupLength), .dataValid(dataValid), .dataByte(dataByte),
    .dataLast(dataLast), .dataReady(dataReady), .overRun(overRun));

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Ends 1 ns after the edge that shows done or stall
  task automatic xfer(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
                      input logic [15:0] len);
    int n;
    @(posedge clk);
    setupValid <= 1'b1;
    setupRequestType <= rt;
    setupRequest <= rq;
    setupValue <= val;
    setupLength <= len;
    @(posedge clk);
    setupValid <= 1'b0;
    #1;
    for (n = 0; n < 400; n++) begin
      if (reqDone === 1'b1 || reqStall === 1'b1) break;
      @(posedge clk);
      #1;
    end
    sawStall = reqStall;
    if (n == 400) begin
      fails++;
      $display("[ERR] wait expected 1 seen 0");
      end_sim();
    end
  endtask : xfer

  task automatic cmpBuf(input logic [199:0] exp, input int n);
    check("count", n[7:0], i_host.rxCount[7:0]);
    check("overrun", 8'h00, {7'h0, overRun});
    check("last", 8'(n - 1), i_host.lastIdx[7:0]);
    for (int i = 0; i < n; i++) check("byte", exp[8*(n-1-i) +: 8], i_host.rxBytes[i]);
  endtask : cmpBuf

  function automatic logic [7:0] hexChar(input logic [3:0] d);
    return (d < 4'hA) ? 8'h30 + d : 8'h37 + d;
  endfunction : hexChar

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      xfer(8'h80, 8'h06, rows[i].val, rows[i].len);
      cmpBuf(rows[i].exp, rows[i].n);
      $display("row %0d done", i);
    end
    // ======================================================================
    // Full strings through a slow host
    slowMode <= 1'b1;
    xfer(8'h80, 8'h06, 16'h0301, 16'hFFFF);
    check("mfg count", 8'h24, i_host.rxCount[7:0]);
    check("mfg len", 8'h24, i_host.rxBytes[0]);
    check("mfg type", 8'h03, i_host.rxBytes[1]);
    check("mfg overrun", 8'h00, {7'h0, overRun});
    check("mfg last", 8'h23, i_host.lastIdx[7:0]);
    for (int k = 0; k < 17; k++) begin
      check("mfg char", MFG[8*(16-k) +: 8], i_host.rxBytes[2+2*k]);
      check("mfg high", 8'h00, i_host.rxBytes[3+2*k]);
    end
    @(posedge clk);
    serialNumberBytes <= 64'hFEDCBA9876543210;
    xfer(8'h80, 8'h06, 16'h0303, 16'hFFFF);
    check("serial len", 8'h22, i_host.rxBytes[0]);
    check("serial count", 8'h22, i_host.rxCount[7:0]);
    check("serial type", 8'h03, i_host.rxBytes[1]);
    for (int k = 0; k < 16; k++) begin
      check("digit", hexChar(serialNumberBytes[8*(k/2)+4*(1-k%2) +: 4]),
            i_host.rxBytes[2+2*k]);
      check("digit high", 8'h00, i_host.rxBytes[3+2*k]);
    end
    $display("strings done");
    // ======================================================================
    // Refused requests and zero length
    slowMode <= 1'b0;
    xfer(8'h00, 8'h06, 16'h0100, 16'h0040);
    check("stall type", 8'h01, {7'h0, sawStall});
    xfer(8'h80, 8'h05, 16'h0100, 16'h0040);
    check("stall req", 8'h01, {7'h0, sawStall});
    xfer(8'h80, 8'h06, 16'h0304, 16'h0040);
    check("stall index", 8'h01, {7'h0, sawStall});
    xfer(8'h80, 8'h06, 16'h0101, 16'h0040);
    check("stall dev idx", 8'h01, {7'h0, sawStall});
    xfer(8'h80, 8'h06, 16'h0600, 16'h0040);
    check("stall kind", 8'h01, {7'h0, sawStall});
    xfer(8'h80, 8'h06, 16'h0100, 16'h0000);
    check("zero len", 8'h00, {7'h0, sawStall});
    cmpBuf(200'h0, 0);
    $display("refusals done");
    // ======================================================================
    // Reset in mid transfer, then a clean request
    @(posedge clk);
    slowMode <= 1'b1;
    setupValid <= 1'b1;
    setupRequestType <= 8'h80;
    setupRequest <= 8'h06;
    setupValue <= 16'h0200;
    setupLength <= 16'hFFFF;
    @(posedge clk);
    setupValid <= 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    slowMode <= 1'b0;
    #1;
    check("valid after reset", 8'h00, {7'h0, dataValid});
    xfer(8'h80, 8'h06, 16'h0300, 16'hFFFF);
    cmpBuf(32'h04030904, 4);
    $display("reset done");
    end_sim();
  end
endmodule : boot_usb_descriptor_rom_tb
